// ---- pkg/rx_cfg_map.svh ----
`ifndef RX_CFG_MAP_SVH
`define RX_CFG_MAP_SVH

// Serial frame: command nibble, address nibble, data byte
`define RX_CMD_WRITE 4'h1
`define RX_CMD_READ 4'h2
`define RX_CMD_RESET 4'h3
`define RX_FRAME_BITS 5'h10
`define RX_HDR_BITS 5'h08

// Register addresses
`define RX_ADDR_CONFIG 4'h1
`define RX_ADDR_CONTROL 4'h2
`define RX_ADDR_STATUS 4'h9

// Reset values and writable masks
`define RX_CONFIG_RESET 8'h40
`define RX_CONTROL_RESET 8'h00
`define RX_CONFIG_MASK 8'h7F
`define RX_CONTROL_MASK 8'h4F

// Configuration fields
`define RX_CFG_GAIN_BIT 6
`define RX_CFG_PRECISE_BIT 5
`define RX_CFG_FSK_SDO_BIT 4
`define RX_CFG_ASK_SDO_BIT 3
`define RX_CFG_PS_HI_BIT 2
`define RX_CFG_PS_LO_BIT 1
`define RX_CFG_DRX_BIT 0

// Control fields
`define RX_CTL_HOLD_BIT 6
`define RX_CTL_FSK_TRK_BIT 3
`define RX_CTL_ASK_TRK_BIT 2
`define RX_CTL_POLL_CAL_BIT 1
`define RX_CTL_FSK_CAL_BIT 0

// Status fields
`define RX_STS_GAIN_BIT 6
`define RX_STS_POLL_BIT 1
`define RX_STS_FSK_BIT 0

// Timing
`define RX_CLK_PERIOD_NS 40
`define RX_OFF_BASE_NS 120000
`define RX_OFF_BASE_CYCLES (`RX_OFF_BASE_NS / `RX_CLK_PERIOD_NS)
`define RX_POLL_CAL_NS 1000000
`define RX_FSK_QUICK_NS 200000
`define RX_FSK_PRECISE_NS 1000000
`define RX_POLL_CAL_CYCLES (`RX_POLL_CAL_NS / `RX_CLK_PERIOD_NS)
`define RX_FSK_QUICK_CYCLES (`RX_FSK_QUICK_NS / `RX_CLK_PERIOD_NS)
`define RX_FSK_PRECISE_CYCLES (`RX_FSK_PRECISE_NS / `RX_CLK_PERIOD_NS)

`endif

// ---- pkg/rx_cfg_pkg.sv ----
package rx_cfg_pkg;
    typedef logic [7:0] reg_t;
    typedef logic [19:0] cal_len_t;
    typedef enum logic {CAL_IDLE, CAL_RUN} cal_state_e;
endpackage

// ---- rtl/cal_engine.sv ----
`timescale 1ns/1ps
`default_nettype none
module cal_engine (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Request
    input wire logic start,
    input wire rx_cfg_pkg::cal_len_t length,
    // Progress
    output logic busy,
    output logic done
);
    import rx_cfg_pkg::*;

    cal_state_e state;
    cal_state_e next_state;
    cal_len_t count;
    cal_len_t next_count;
    logic next_done;

    always_comb
    begin
        next_state = state;
        next_count = count;
        next_done = 1'b0;
        case (state)
            CAL_IDLE:
            begin
                // A start while running is ignored
                if (start)
                begin
                    next_state = CAL_RUN;
                    next_count = length - 20'h00001;
                end
            end
            CAL_RUN:
            begin
                if (count == 20'h00000)
                begin
                    next_state = CAL_IDLE;
                    next_done = 1'b1;
                end
                else
                begin
                    next_count = count - 20'h00001;
                end
            end
            default:
            begin
                next_state = CAL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= CAL_IDLE;
            count <= 20'h00000;
            done <= 1'b0;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
            done <= next_done;
        end
    end

    assign busy = (state == CAL_RUN);
endmodule
`default_nettype wire

// ---- rtl/rx_config_control_regs.sv ----
// What this block does
// R1: Config bit 6 selects LNA high gain, resets 1
// R2: Host forms manual gain via AGC enable toggle
// R3: Config bit 5 selects long precise FSK calibration
// R4: Config bit 4 routes serial out to FSK pin
// R5: Config bit 3 routes serial out to ASK pin
// R6: Config bits 2:1 set off-timer LSB size
// R7: Config bit 0 selects discontinuous receive, resets 0
// R8: Control bit 6 freezes present LNA gain
// R9: Control bit 3 enables FSK peak tracking
// R10: Control bit 2 enables ASK peak tracking
// R11: Writing control bit 1 starts polling calibration
// R12: Polling start bit clears when calibration completes
// R13: Host calibrates polling timer before discontinuous mode
// R14: Writing control bit 0 starts FSK calibration
// R15: FSK start bit clears when calibration completes
// R16: Polling flag reads 1 once calibration complete
// R17: FSK flag reads 0 until calibration finished
// R18: Unused bits ignore writes, read zero
`timescale 1ns/1ps
`default_nettype none
`include "rx_cfg_map.svh"
module rx_config_control_regs #(
    parameter rx_cfg_pkg::cal_len_t POLL_CAL_CYCLES = 20'(`RX_POLL_CAL_CYCLES),
    parameter rx_cfg_pkg::cal_len_t FSK_QUICK_CYCLES = 20'(`RX_FSK_QUICK_CYCLES),
    parameter rx_cfg_pkg::cal_len_t FSK_PRECISE_CYCLES = 20'(`RX_FSK_PRECISE_CYCLES)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Serial interface pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic dio_in,
    output logic dio_out,
    output logic dio_oe,
    // Demodulated data and data pins
    input wire logic ask_demod,
    input wire logic fsk_demod,
    output logic ask_data_pin,
    output logic fsk_data_pin,
    // Gain control
    input wire logic auto_gain_enable,
    input wire logic agc_gain_request,
    output logic lna_high_gain,
    // Configuration and control outputs
    output logic fsk_cal_precise,
    output logic discontinuous_rx_select,
    output logic off_lsb_tick,
    output logic fsk_peak_track,
    output logic ask_peak_track,
    output logic poll_cal_busy,
    output logic fsk_cal_busy
);
    import rx_cfg_pkg::*;

    // Shorter runs would break the two-cycle busy guarantee
    if (POLL_CAL_CYCLES < 20'h00003 || FSK_QUICK_CYCLES < 20'h00003
        || FSK_PRECISE_CYCLES < 20'h00003)
    begin : g_bad_len
        $error("Calibration lengths must be at least three cycles");
    end

    localparam int NSYNC = 6;
    localparam logic [17:0] OFF_BASE = 18'(`RX_OFF_BASE_CYCLES);

    // Two-flop synchronisers: sclk, cs_n, dio, ask, fsk, agc request
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic [NSYNC-1:0] sync3;
    assign raw_in = {agc_gain_request, fsk_demod, ask_demod, dio_in, cs_n, sclk};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1)
        begin : g_sync
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    sync1[gi] <= 1'b1;
                    sync2[gi] <= 1'b1;
                    sync3[gi] <= 1'b1;
                end
                else
                begin
                    sync1[gi] <= raw_in[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                end
            end
        end
    endgenerate

    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic cs_fall;
    logic cs_low;
    logic agc_change;
    assign sclk_rise = sync2[0] & ~sync3[0];
    assign sclk_fall = ~sync2[0] & sync3[0];
    assign cs_rise = sync2[1] & ~sync3[1];
    assign cs_fall = ~sync2[1] & sync3[1];
    assign cs_low = ~sync2[1];
    assign agc_change = sync2[5] ^ sync3[5];

    // Register state
    reg_t config_q;
    reg_t control_q;
    logic poll_flag;
    logic fsk_flag;
    logic [4:0] bit_cnt;
    logic [15:0] shift_in;
    reg_t shift_out;
    logic rd_active;
    logic [17:0] off_cnt;
    reg_t next_config;
    reg_t next_control;
    logic next_poll_flag;
    logic next_fsk_flag;
    logic [4:0] next_bit_cnt;
    logic [15:0] next_shift_in;
    reg_t next_shift_out;
    logic next_rd_active;
    logic next_gain;
    logic [17:0] next_off_cnt;
    logic next_off_tick;
    logic next_dio_out;
    logic next_dio_oe;
    logic next_ask_pin;
    logic next_fsk_pin;

    // Frame decode
    logic frame_done;
    logic wr_cfg;
    logic wr_ctl;
    logic soft_rst;
    reg_t wr_data;
    assign frame_done = cs_rise && (bit_cnt == `RX_FRAME_BITS);
    assign wr_data = shift_in[7:0];
    assign wr_cfg = frame_done && shift_in[15:12] == `RX_CMD_WRITE
        && shift_in[11:8] == `RX_ADDR_CONFIG;
    assign wr_ctl = frame_done && shift_in[15:12] == `RX_CMD_WRITE
        && shift_in[11:8] == `RX_ADDR_CONTROL;
    assign soft_rst = frame_done && shift_in[15:12] == `RX_CMD_RESET;

    // Calibration engines
    logic poll_start;
    logic fsk_start;
    logic poll_done;
    logic fsk_done;
    logic poll_busy_w;
    logic fsk_busy_w;
    cal_len_t fsk_len;
    assign poll_start = wr_ctl && wr_data[`RX_CTL_POLL_CAL_BIT]; // [R11]
    assign fsk_start = wr_ctl && wr_data[`RX_CTL_FSK_CAL_BIT]; // [R14]
    // Precise calibration trades time for accuracy
    assign fsk_len = config_q[`RX_CFG_PRECISE_BIT] ? FSK_PRECISE_CYCLES
        : FSK_QUICK_CYCLES; // [R3]

    cal_engine u_poll_cal (
        .clk(clk),
        .nrst(nrst),
        .start(poll_start),
        .length(POLL_CAL_CYCLES),
        .busy(poll_busy_w),
        .done(poll_done)
    );

    cal_engine u_fsk_cal (
        .clk(clk),
        .nrst(nrst),
        .start(fsk_start),
        .length(fsk_len),
        .busy(fsk_busy_w),
        .done(fsk_done)
    );

    function automatic reg_t read_reg(input logic [3:0] addr);
        reg_t v;
        v = 8'h00;
        case (addr)
            `RX_ADDR_CONFIG: v = config_q;
            `RX_ADDR_CONTROL: v = control_q;
            `RX_ADDR_STATUS:
            begin
                v[`RX_STS_GAIN_BIT] = lna_high_gain;
                v[`RX_STS_POLL_BIT] = poll_flag; // [R16]
                v[`RX_STS_FSK_BIT] = fsk_flag; // [R17]
            end
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    always_comb
    begin
        next_config = config_q;
        next_control = control_q;
        next_poll_flag = poll_flag;
        next_fsk_flag = fsk_flag;
        next_bit_cnt = bit_cnt;
        next_shift_in = shift_in;
        next_shift_out = shift_out;
        next_rd_active = rd_active;
        next_gain = lna_high_gain;
        // Serial shifter
        if (cs_fall || cs_rise)
        begin
            next_bit_cnt = 5'h00;
            next_rd_active = 1'b0;
        end
        else if (cs_low && sclk_rise && bit_cnt != `RX_FRAME_BITS)
        begin
            next_shift_in = {shift_in[14:0], sync2[2]};
            next_bit_cnt = bit_cnt + 5'h01;
            if (bit_cnt + 5'h01 == `RX_HDR_BITS && shift_in[6:3] == `RX_CMD_READ)
            begin
                next_rd_active = 1'b1;
                next_shift_out = read_reg({shift_in[2:0], sync2[2]});
            end
        end
        else if (cs_low && sclk_fall && rd_active && bit_cnt > `RX_HDR_BITS)
        begin
            next_shift_out = {shift_out[6:0], 1'b0};
        end
        // Register writes
        if (wr_cfg)
        begin
            next_config = wr_data & `RX_CONFIG_MASK; // [R18]
        end
        if (wr_ctl)
        begin
            next_control = wr_data & `RX_CONTROL_MASK; // [R18]
        end
        else
        begin
            if (poll_done)
            begin
                next_control[`RX_CTL_POLL_CAL_BIT] = 1'b0; // [R12]
            end
            if (fsk_done)
            begin
                next_control[`RX_CTL_FSK_CAL_BIT] = 1'b0; // [R15]
            end
        end
        // Flags: completion wins over a new start
        if (poll_start && !poll_busy_w)
        begin
            next_poll_flag = 1'b0;
        end
        if (poll_done)
        begin
            next_poll_flag = 1'b1; // [R16]
        end
        if (fsk_start && !fsk_busy_w)
        begin
            next_fsk_flag = 1'b0; // [R17]
        end
        if (fsk_done)
        begin
            next_fsk_flag = 1'b1; // [R17]
        end
        // Gain: frozen under hold or with auto gain disabled, else config writes or AGC request follows
        if (!control_q[`RX_CTL_HOLD_BIT] && auto_gain_enable) // [R8]
        begin
            if (wr_cfg)
            begin
                next_gain = wr_data[`RX_CFG_GAIN_BIT]; // [R1]
            end
            else if (agc_change)
            begin
                next_gain = sync2[5];
            end
        end
        if (soft_rst)
        begin
            next_config = `RX_CONFIG_RESET;
            next_control = `RX_CONTROL_RESET;
        end
    end

    // Off-timer LSB tick: base times 1, 4, 16 or 64
    always_comb
    begin
        next_off_tick = 1'b0;
        next_off_cnt = off_cnt - 18'h00001;
        if (off_cnt == 18'h00000)
        begin
            next_off_tick = 1'b1;
            next_off_cnt = (OFF_BASE << {config_q[`RX_CFG_PS_HI_BIT],
                config_q[`RX_CFG_PS_LO_BIT], 1'b0}) - 18'h00001; // [R6]
        end
    end

    // Pin drive: 4-wire mode moves read data off the DIO pin
    always_comb
    begin
        next_dio_out = shift_out[7];
        next_dio_oe = rd_active && cs_low && !config_q[`RX_CFG_FSK_SDO_BIT]
            && !config_q[`RX_CFG_ASK_SDO_BIT];
        next_fsk_pin = config_q[`RX_CFG_FSK_SDO_BIT] ? shift_out[7] : sync2[4]; // [R4]
        next_ask_pin = config_q[`RX_CFG_ASK_SDO_BIT] ? shift_out[7] : sync2[3]; // [R5]
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            config_q <= `RX_CONFIG_RESET; // [R1] [R7]
            control_q <= `RX_CONTROL_RESET;
            poll_flag <= 1'b0;
            fsk_flag <= 1'b0;
            bit_cnt <= 5'h00;
            shift_in <= 16'h0000;
            shift_out <= 8'h00;
            rd_active <= 1'b0;
            lna_high_gain <= 1'b1;
            off_cnt <= 18'h00000;
            off_lsb_tick <= 1'b0;
            dio_out <= 1'b0;
            dio_oe <= 1'b0;
            fsk_data_pin <= 1'b0;
            ask_data_pin <= 1'b0;
            poll_cal_busy <= 1'b0;
            fsk_cal_busy <= 1'b0;
        end
        else
        begin
            config_q <= next_config;
            control_q <= next_control;
            poll_flag <= next_poll_flag;
            fsk_flag <= next_fsk_flag;
            bit_cnt <= next_bit_cnt;
            shift_in <= next_shift_in;
            shift_out <= next_shift_out;
            rd_active <= next_rd_active;
            lna_high_gain <= next_gain;
            off_cnt <= next_off_cnt;
            off_lsb_tick <= next_off_tick;
            dio_out <= next_dio_out;
            dio_oe <= next_dio_oe;
            fsk_data_pin <= next_fsk_pin;
            ask_data_pin <= next_ask_pin;
            poll_cal_busy <= poll_busy_w;
            fsk_cal_busy <= fsk_busy_w;
        end
    end

    assign fsk_cal_precise = config_q[`RX_CFG_PRECISE_BIT]; // [R3]
    assign discontinuous_rx_select = config_q[`RX_CFG_DRX_BIT]; // [R7]
    assign fsk_peak_track = control_q[`RX_CTL_FSK_TRK_BIT]; // [R9]
    assign ask_peak_track = control_q[`RX_CTL_ASK_TRK_BIT]; // [R10]

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    property p_gain_write;
        (wr_cfg && auto_gain_enable && !control_q[`RX_CTL_HOLD_BIT])
            |=> lna_high_gain == $past(wr_data[`RX_CFG_GAIN_BIT]);
    endproperty
    a_gain_write: assert property (p_gain_write) else $error("Gain not loaded from write"); // [R1]

    property p_hold;
        control_q[`RX_CTL_HOLD_BIT] |=> $stable(lna_high_gain);
    endproperty
    a_hold: assert property (p_hold) else $error("Gain moved while held"); // [R8]

    property p_unused_zero;
        config_q[7] == 1'b0 && control_q[7] == 1'b0 && control_q[5:4] == 2'b00;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("Unused bit set"); // [R18]

    property p_poll_clear;
        (poll_done && !wr_ctl) |=> !control_q[`RX_CTL_POLL_CAL_BIT] && poll_flag;
    endproperty
    a_poll_clear: assert property (p_poll_clear) else $error("Poll start not cleared"); // [R12]

    property p_fsk_clear;
        (fsk_done && !wr_ctl) |=> !control_q[`RX_CTL_FSK_CAL_BIT] && fsk_flag;
    endproperty
    a_fsk_clear: assert property (p_fsk_clear) else $error("FSK start not cleared"); // [R15]

    // A done in the start cycle still sets the flag
    property p_fsk_run;
        (fsk_start && !fsk_busy_w && !fsk_done) |=> !fsk_flag ##0 fsk_busy_w [*2];
    endproperty
    a_fsk_run: assert property (p_fsk_run) else $error("FSK calibration did not run"); // [R14]

    property p_poll_run;
        (poll_start && !poll_busy_w) |=> poll_busy_w ##1 poll_cal_busy;
    endproperty
    a_poll_run: assert property (p_poll_run) else $error("Poll calibration did not run"); // [R11]

    property p_fsk_pin;
        config_q[`RX_CFG_FSK_SDO_BIT] |=> fsk_data_pin == $past(shift_out[7]) && !dio_oe;
    endproperty
    a_fsk_pin: assert property (p_fsk_pin) else $error("FSK pin not serial out"); // [R4]

    property p_off_tick;
        off_lsb_tick |-> off_cnt == (OFF_BASE << {config_q[`RX_CFG_PS_HI_BIT],
            config_q[`RX_CFG_PS_LO_BIT], 1'b0}) - 18'h00001 || $changed(config_q);
    endproperty
    a_off_tick: assert property (p_off_tick) else $error("Off tick period wrong"); // [R6]
endmodule
`default_nettype wire

// ---- verif/host_link.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_link (
    // Clock
    input wire logic clk,
    // Request
    input wire logic go,
    input wire logic [15:0] frame,
    input wire logic [1:0] src,
    // Lines seen
    input wire logic dio_line,
    input wire logic ask_pin,
    input wire logic fsk_pin,
    // Lines driven
    output logic sclk,
    output logic cs_n,
    output logic host_out,
    output logic host_oe,
    // Answer
    output logic [7:0] rdata,
    output logic done
);
    logic line;
    assign line = (src == 2'h0) ? dio_line : ((src == 2'h1) ? ask_pin : fsk_pin);
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        host_out = 1'b0;
        host_oe = 1'b0;
        rdata = 8'h00;
        done = 1'b0;
        forever
        begin
            @(posedge clk);
            if (go)
            begin
                cs_n <= 1'b0;
                for (int i = 15; i >= 0; i--)
                begin
                    // Released in the read data phase
                    host_oe <= !(i < 8 && frame[15:12] == 4'h2);
                    host_out <= frame[i];
                    repeat (4) @(posedge clk);
                    sclk <= 1'b1;
                    repeat (4) @(posedge clk);
                    // Late in high phase: data moves some clocks after each fall
                    if (i < 8)
                    begin
                        rdata[i] <= line;
                    end
                    sclk <= 1'b0;
                end
                repeat (4) @(posedge clk);
                cs_n <= 1'b1;
                host_oe <= 1'b0;
                repeat (6) @(posedge clk);
                done <= 1'b1;
                @(posedge clk);
                done <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verif/test_rx_config_control_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rx_cfg_map.svh"
module test_rx_config_control_regs;
    import rx_cfg_pkg::*;
    localparam cal_len_t POLL = 20'h00190;
    localparam cal_len_t QUICK = 20'h00190;
    localparam cal_len_t PRECISE = 20'h00320;
    logic clk, nrst, sclk, cs_n, dio_in, dio_out, dio_oe, ask_demod, fsk_demod;
    logic ask_data_pin, fsk_data_pin, auto_gain_enable, agc_gain_request, lna_high_gain;
    logic fsk_cal_precise, discontinuous_rx_select, off_lsb_tick, fsk_peak_track;
    logic ask_peak_track, poll_cal_busy, fsk_cal_busy, host_out, host_oe, go, done;
    logic [15:0] frame;
    logic [1:0] src;
    logic [7:0] rdata;
    logic [31:0] p, fsk_cnt, poll_cnt;
    int fails, samples_checked;
    // Pull-up on the shared data line
    assign dio_in = dio_oe ? dio_out : (host_oe ? host_out : 1'b1);
    rx_config_control_regs #(.POLL_CAL_CYCLES(POLL), .FSK_QUICK_CYCLES(QUICK),
        .FSK_PRECISE_CYCLES(PRECISE)) rx_config_control_regs_i (
        .clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .dio_in(dio_in),
        .dio_out(dio_out), .dio_oe(dio_oe), .ask_demod(ask_demod), .fsk_demod(fsk_demod),
        .ask_data_pin(ask_data_pin), .fsk_data_pin(fsk_data_pin),
        .auto_gain_enable(auto_gain_enable), .agc_gain_request(agc_gain_request),
        .lna_high_gain(lna_high_gain), .fsk_cal_precise(fsk_cal_precise),
        .discontinuous_rx_select(discontinuous_rx_select), .off_lsb_tick(off_lsb_tick),
        .fsk_peak_track(fsk_peak_track), .ask_peak_track(ask_peak_track),
        .poll_cal_busy(poll_cal_busy), .fsk_cal_busy(fsk_cal_busy));
    host_link host_link_i (.clk(clk), .go(go), .frame(frame), .src(src), .dio_line(dio_in),
        .ask_pin(ask_data_pin), .fsk_pin(fsk_data_pin), .sclk(sclk), .cs_n(cs_n),
        .host_out(host_out), .host_oe(host_oe), .rdata(rdata), .done(done));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Free-running busy counters, read as differences
    always @(posedge clk)
    begin
        if (nrst !== 1'b1)
        begin
            fsk_cnt <= 32'h0;
            poll_cnt <= 32'h0;
        end
        else
        begin
            if (fsk_cal_busy === 1'b1) fsk_cnt <= fsk_cnt + 32'h1;
            if (poll_cal_busy === 1'b1) poll_cnt <= poll_cnt + 32'h1;
        end
    end
    task stop_test;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task xfer(input logic [15:0] f);
        int n;
        frame <= f;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 400)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 400) fails++;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        xfer({4'h1, a, d});
    endtask
    task rd(input logic [3:0] a, input logic [7:0] exp, input logic [1:0] s);
        src <= s;
        xfer({4'h2, a, 8'h00});
        check(32'(rdata), 32'(exp));
    endtask
    task wait_idle;
        int n;
        n = 0;
        while ((fsk_cal_busy !== 1'b0 || poll_cal_busy !== 1'b0) && n < 3000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 3000) fails++;
        repeat (2) @(posedge clk);
    endtask
    task tick_period(output logic [31:0] per);
        int n;
        n = 0;
        while (off_lsb_tick !== 1'b1 && n < 20000)
        begin
            @(posedge clk);
            n++;
        end
        per = 32'h0;
        do
        begin
            @(posedge clk);
            per++;
        end while (off_lsb_tick !== 1'b1 && per < 32'd20000);
    endtask
    task near(input logic [31:0] got, input logic [31:0] exp);
        // Busy edges may land a clock either side of the engine count
        check(32'(got + 32'h1 >= exp && got <= exp + 32'h1), 32'h1);
    endtask
    initial
    begin
        #2400000;
        fails++;
        stop_test();
    end
    initial
    begin
        nrst = 1'b0; ask_demod = 1'b0; fsk_demod = 1'b0; auto_gain_enable = 1'b0;
        agc_gain_request = 1'b0; go = 1'b0; frame = 16'h0000; src = 2'h0;
        fails = 0; samples_checked = 0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (5) @(posedge clk);
        check(32'(lna_high_gain), 32'h1);
        check(32'({discontinuous_rx_select, fsk_peak_track, ask_peak_track}), 32'h0);
        rd(4'h1, 8'h40, 2'h0);
        rd(4'h2, 8'h00, 2'h0);
        rd(4'h9, 8'h40, 2'h0);
        $display("test reset done");
        wr(4'h1, 8'hFF);
        check(32'({fsk_cal_precise, discontinuous_rx_select}), 32'h3);
        rd(4'h1, 8'h7F, 2'h1);
        rd(4'h1, 8'h7F, 2'h2);
        wr(4'h1, 8'h00);
        rd(4'h1, 8'h00, 2'h0);
        fsk_demod <= 1'b1;
        repeat (6) @(posedge clk);
        check(32'({fsk_data_pin, ask_data_pin}), 32'h2);
        fsk_demod <= 1'b0;
        ask_demod <= 1'b1;
        repeat (6) @(posedge clk);
        check(32'({fsk_data_pin, ask_data_pin}), 32'h1);
        $display("test config done");
        tick_period(p);
        check(p, 32'(`RX_OFF_BASE_CYCLES));
        wr(4'h1, 8'h02);
        tick_period(p);
        check(p, 32'(`RX_OFF_BASE_CYCLES) * 32'h4);
        $display("test off timer done");
        auto_gain_enable <= 1'b1;
        wr(4'h1, 8'h00);
        check(32'(lna_high_gain), 32'h0);
        wr(4'h1, 8'h40);
        check(32'(lna_high_gain), 32'h1);
        auto_gain_enable <= 1'b0;
        wr(4'h1, 8'h00);
        check(32'(lna_high_gain), 32'h1);
        auto_gain_enable <= 1'b1;
        wr(4'h2, 8'h40);
        wr(4'h1, 8'h00);
        check(32'(lna_high_gain), 32'h1);
        agc_gain_request <= 1'b1;
        repeat (6) @(posedge clk);
        check(32'(lna_high_gain), 32'h1);
        wr(4'h2, 8'h00);
        wr(4'h1, 8'h00);
        check(32'(lna_high_gain), 32'h0);
        agc_gain_request <= 1'b0;
        repeat (6) @(posedge clk);
        agc_gain_request <= 1'b1;
        repeat (6) @(posedge clk);
        check(32'(lna_high_gain), 32'h1);
        auto_gain_enable <= 1'b0;
        $display("test gain done");
        wr(4'h2, 8'hFC);
        rd(4'h2, 8'h4C, 2'h0);
        check(32'({fsk_peak_track, ask_peak_track}), 32'h3);
        wr(4'h2, 8'h0C);
        wr(4'h1, 8'h35);
        wr(4'h7, 8'hAA);
        // Config 0x35 moves read data to the FSK pin
        rd(4'h7, 8'h00, 2'h2);
        rd(4'h1, 8'h35, 2'h2);
        xfer(16'h3000);
        rd(4'h1, 8'h40, 2'h0);
        rd(4'h2, 8'h00, 2'h0);
        check(32'({fsk_peak_track, ask_peak_track}), 32'h0);
        $display("test map done");
        wr(4'h1, 8'h40);
        p = fsk_cnt;
        wr(4'h2, 8'h01);
        rd(4'h2, 8'h01, 2'h0);
        rd(4'h9, 8'h40, 2'h0);
        wait_idle();
        near(fsk_cnt - p, 32'(QUICK));
        rd(4'h2, 8'h00, 2'h0);
        rd(4'h9, 8'h41, 2'h0);
        wr(4'h1, 8'h60);
        p = fsk_cnt;
        wr(4'h2, 8'h01);
        wait_idle();
        near(fsk_cnt - p, 32'(PRECISE));
        p = poll_cnt;
        wr(4'h2, 8'h02);
        rd(4'h2, 8'h02, 2'h0);
        rd(4'h9, 8'h41, 2'h0);
        wait_idle();
        near(poll_cnt - p, 32'(POLL));
        rd(4'h2, 8'h00, 2'h0);
        rd(4'h9, 8'h43, 2'h0);
        wr(4'h1, 8'h41);
        check(32'(discontinuous_rx_select), 32'h1);
        $display("test calibration done");
        stop_test();
    end
endmodule
`default_nettype wire
